// ===== include/mmd_portal_pkg.sv
package mmd_portal_pkg;
    localparam int DATA_W = 16;
    localparam int DEVAD_W = 5;
    // Setup register fields
    localparam int FUNC_HI = 15;
    localparam int FUNC_LO = 14;
    localparam int DEVAD_HI = 4;
    localparam logic [1:0] FUNC_ADDRESS = 2'h0;
    localparam logic [1:0] FUNC_DATA = 2'h1;
    // Indirect map
    localparam logic [4:0] DEV_LED = 5'h02;
    localparam logic [4:0] DEV_WAKE = 5'h03;
    localparam logic [4:0] DEV_ADVERT = 5'h07;
    localparam logic [15:0] REG_LED_MODE = 16'h0000;
    localparam logic [15:0] REG_WAKE_TIMER = 16'h000e;
    localparam logic [15:0] REG_ADVERT = 16'h003c;
    // Field positions and resets
    localparam int LED_MODE_BIT = 4;
    localparam int ADVERT_100_BIT = 1;
    localparam logic [3:0] LED_LOW_FIXED = 4'h1;
    localparam logic LED_MODE_RST = 1'b0;
    localparam logic ADVERT_100_RST = 1'b1;
    localparam logic [15:0] WAKE_TIMER_RST = 16'h0025;

    typedef enum logic [0:0]
    {
        FN_ADDR = 1'b0,
        FN_DATA = 1'b1
    } portal_fn_t;

    typedef struct packed
    {
        logic wr_setup;
        logic wr_data;
        logic rd_data;
        logic [15:0] wdata;
    } port_req_t;

    typedef struct packed
    {
        portal_fn_t fn;
        logic [4:0] devad;
        logic [15:0] regad;
        logic led_mode;
        logic advert_100;
        logic [15:0] wake_time;
        logic [15:0] rdata;
        logic rvalid;
    } portal_state_t;
endpackage

// ===== core/mmd_indirect_register_access.sv
`timescale 1ns/1ps
// Function
// - Indirect space of 32 devices by 65536 sixteen-bit registers, few implemented.
// - Indirect registers are reached only through the setup and data port registers.
// - Setup write 0002h form selects address function; next data write latches the address.
// - Setup write 4002h form selects data function; data accesses then hit that register.
// - In data function a data write stores and a data read returns the selected register.
// - LED mode lives at device 2h reg 00h and advertisement at device 7h reg 3Ch.
// - Wake timer at device 03h reg 0Eh is 16-bit read/write and resets to 0025h.
// - Advertisement bit 1 is read/write, resets to 1, set means 100M low-power capable.
module mmd_indirect_register_access
    import mmd_portal_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire port_req_t req_in,
    output logic [15:0] rdata_out,
    output logic rvalid_out,
    output logic single_led_out,
    output logic advert_100_out,
    output logic [15:0] wake_refresh_time_out
);
    portal_state_t st;
    portal_state_t next_st;

    // Full decode of device and register, so aliases cannot catch stray writes
    function automatic logic hit(input logic [4:0] dv, input logic [15:0] ra,
                                 input logic [4:0] tdv, input logic [15:0] tra);
        hit = (dv == tdv) && (ra == tra);
    endfunction

    function automatic logic [15:0] read_reg(input portal_state_t s);
        logic [15:0] v;
        v = '0;
        if (hit(s.devad, s.regad, DEV_LED, REG_LED_MODE))
        begin
            v[$bits(LED_LOW_FIXED)-1:0] = LED_LOW_FIXED;
            v[LED_MODE_BIT] = s.led_mode;
        end
        else if (hit(s.devad, s.regad, DEV_WAKE, REG_WAKE_TIMER))
        begin
            v = s.wake_time;
        end
        else if (hit(s.devad, s.regad, DEV_ADVERT, REG_ADVERT))
        begin
            v[ADVERT_100_BIT] = s.advert_100;
        end
        read_reg = v;
    endfunction

    always_comb
    begin
        next_st = st;
        next_st.rvalid = 1'b0;
        // Setup wins over data strobes, so a stray data pulse in the same cycle
        // cannot reach a register whose selection is still changing
        if (req_in.wr_setup)
        begin
            // Function code 2'b10/11 not defined here; treated as data access
            next_st.fn = (req_in.wdata[FUNC_HI:FUNC_LO] == FUNC_ADDRESS) ? FN_ADDR : FN_DATA;
            next_st.devad = req_in.wdata[DEVAD_HI:0];
        end
        else if (req_in.wr_data)
        begin
            if (st.fn == FN_ADDR)
            begin
                next_st.regad = req_in.wdata;
            end
            else
            begin
                // Only the writable bits are kept; reserved bits are dropped
                if (hit(st.devad, st.regad, DEV_LED, REG_LED_MODE))
                begin
                    next_st.led_mode = req_in.wdata[LED_MODE_BIT];
                end
                if (hit(st.devad, st.regad, DEV_WAKE, REG_WAKE_TIMER))
                begin
                    next_st.wake_time = req_in.wdata;
                end
                if (hit(st.devad, st.regad, DEV_ADVERT, REG_ADVERT))
                begin
                    next_st.advert_100 = req_in.wdata[ADVERT_100_BIT];
                end
            end
        end
        else if (req_in.rd_data)
        begin
            // Reading in address function returns the latched register address
            next_st.rdata = (st.fn == FN_DATA) ? read_reg(st) : st.regad;
            next_st.rvalid = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            // Portal comes back in the address function with nothing selected
            st <= '{
                fn: FN_ADDR,
                devad: '0,
                regad: '0,
                led_mode: LED_MODE_RST,
                advert_100: ADVERT_100_RST,
                wake_time: WAKE_TIMER_RST,
                rdata: '0,
                rvalid: 1'b0
            };
        end
        else
        begin
            st <= next_st;
        end
    end

    // Config outputs are the register bits themselves, no extra stage
    assign rdata_out = st.rdata;
    assign rvalid_out = st.rvalid;
    assign single_led_out = st.led_mode;
    assign advert_100_out = st.advert_100;
    assign wake_refresh_time_out = st.wake_time;

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (sys_rst_in);

    // Reset aborts any open attempt, since it moves every output at once
    wake_write_a: assert property
        (req_in.wr_setup == 1'b0 && req_in.wr_data && st.fn == FN_DATA
         && st.devad == DEV_WAKE && st.regad == REG_WAKE_TIMER
         |=> wake_refresh_time_out == $past(req_in.wdata))
        else $error("wake timer write lost");
    addr_latch_a: assert property
        (!req_in.wr_setup && req_in.wr_data && st.fn == FN_ADDR
         |=> st.regad == $past(req_in.wdata) && $stable(wake_refresh_time_out)
             && $stable(single_led_out) && $stable(advert_100_out))
        else $error("address function did not latch address");
    data_fn_a: assert property
        (req_in.wr_setup && req_in.wdata[FUNC_HI:FUNC_LO] == FUNC_DATA
         |=> st.fn == FN_DATA && st.devad == $past(req_in.wdata[DEVAD_HI:0]))
        else $error("data function not selected");
    read_timing_a: assert property
        (!req_in.wr_setup && !req_in.wr_data && req_in.rd_data
         |=> rvalid_out ##1 (!rvalid_out || $past(req_in.rd_data)))
        else $error("read answer not one cycle");
    led_read_a: assert property
        (!req_in.wr_setup && !req_in.wr_data && req_in.rd_data && st.fn == FN_DATA
         && st.devad == DEV_LED && st.regad == REG_LED_MODE
         |=> rdata_out == {11'h000, single_led_out, LED_LOW_FIXED})
        else $error("led mode read wrong");
    advert_read_a: assert property
        (!req_in.wr_setup && !req_in.wr_data && req_in.rd_data && st.fn == FN_DATA
         && st.devad == DEV_ADVERT && st.regad == REG_ADVERT
         |=> rdata_out == {14'h0000, advert_100_out, 1'b0})
        else $error("advertisement read wrong");
    unmapped_a: assert property
        (!req_in.wr_setup && req_in.wr_data && st.fn == FN_DATA && st.devad != DEV_LED
         && st.devad != DEV_WAKE && st.devad != DEV_ADVERT
         |=> $stable(wake_refresh_time_out) && $stable(single_led_out)
             && $stable(advert_100_out))
        else $error("unmapped write had effect");
    map_led_a: assert property
        ($changed(single_led_out) |-> $past(st.devad) == DEV_LED
         && $past(st.regad) == REG_LED_MODE && $past(req_in.wr_data))
        else $error("led mode changed without mapped write");
    led_write_a: assert property
        (!req_in.wr_setup && req_in.wr_data && st.fn == FN_DATA
         && st.devad == DEV_LED && st.regad == REG_LED_MODE
         |=> single_led_out == $past(req_in.wdata[LED_MODE_BIT]))
        else $error("led mode write lost");
    advert_write_a: assert property
        (!req_in.wr_setup && req_in.wr_data && st.fn == FN_DATA
         && st.devad == DEV_ADVERT && st.regad == REG_ADVERT
         |=> advert_100_out == $past(req_in.wdata[ADVERT_100_BIT]))
        else $error("advertisement write lost");
    wake_read_a: assert property
        (!req_in.wr_setup && !req_in.wr_data && req_in.rd_data && st.fn == FN_DATA
         && st.devad == DEV_WAKE && st.regad == REG_WAKE_TIMER
         |=> rdata_out == wake_refresh_time_out)
        else $error("wake timer read wrong");
    addr_fn_a: assert property
        (req_in.wr_setup && req_in.wdata[FUNC_HI:FUNC_LO] == FUNC_ADDRESS
         |=> st.fn == FN_ADDR && st.devad == $past(req_in.wdata[DEVAD_HI:0]))
        else $error("address function not selected");
    addr_read_a: assert property
        (!req_in.wr_setup && !req_in.wr_data && req_in.rd_data && st.fn == FN_ADDR
         |=> rdata_out == $past(st.regad))
        else $error("address function read wrong");
    setup_only_a: assert property
        (req_in.wr_setup
         |=> $stable(st.regad) && $stable(wake_refresh_time_out)
             && $stable(single_led_out) && $stable(advert_100_out))
        else $error("setup write disturbed registers");
    unmapped_read_a: assert property
        (!req_in.wr_setup && !req_in.wr_data && req_in.rd_data && st.fn == FN_DATA
         && st.devad != DEV_LED && st.devad != DEV_WAKE && st.devad != DEV_ADVERT
         |=> rdata_out == '0)
        else $error("unmapped read not zero");
    rvalid_cause_a: assert property
        (rvalid_out |-> $past(req_in.rd_data) && !$past(req_in.wr_setup)
         && !$past(req_in.wr_data))
        else $error("read answer without read");
    rdata_hold_a: assert property
        (!req_in.rd_data |=> $stable(rdata_out))
        else $error("read data changed without read");
    map_wake_a: assert property
        ($changed(wake_refresh_time_out) |-> $past(st.devad) == DEV_WAKE
         && $past(st.regad) == REG_WAKE_TIMER && $past(req_in.wr_data))
        else $error("wake timer changed without mapped write");
    map_advert_a: assert property
        ($changed(advert_100_out) |-> $past(st.devad) == DEV_ADVERT
         && $past(st.regad) == REG_ADVERT && $past(req_in.wr_data))
        else $error("advertisement changed without mapped write");

    // Main traffic: select, write, read back in both functions
    led_cov: cover property (req_in.wr_data && st.fn == FN_DATA && st.devad == DEV_LED
                             ##1 single_led_out);
    wake_cov: cover property (wake_refresh_time_out == 16'h0021);
    read_cov: cover property (rvalid_out && st.fn == FN_DATA);
    addr_read_cov: cover property (req_in.rd_data && st.fn == FN_ADDR ##1 rvalid_out);
    advert_clear_cov: cover property (req_in.wr_data && st.devad == DEV_ADVERT
                                      ##1 !advert_100_out);
endmodule

// ===== bench/mmd_indirect_register_access_tb.sv
`timescale 1ns/1ps
module mmd_indirect_register_access_tb;
    import mmd_portal_pkg::*;
    logic sys_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    port_req_t req_in = '0;
    logic [15:0] rdata_out;
    logic rvalid_out;
    logic single_led_out;
    logic advert_100_out;
    logic [15:0] wake_refresh_time_out;
    int n_fail = 0;
    int comparisons = 0;
    logic [31:0] seed = 32'h7c4b;
    logic m_led = LED_MODE_RST;
    logic m_adv = ADVERT_100_RST;
    logic [15:0] m_wake = WAKE_TIMER_RST;
    logic [4:0] dv;
    logic [15:0] ra;
    always #12.5 sys_clk_in = ~sys_clk_in;
    mmd_indirect_register_access i_mmd_indirect_register_access (.sys_clk_in(sys_clk_in),
        .sys_rst_in(sys_rst_in), .req_in(req_in), .rdata_out(rdata_out),
        .rvalid_out(rvalid_out), .single_led_out(single_led_out),
        .advert_100_out(advert_100_out), .wake_refresh_time_out(wake_refresh_time_out));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [15:0] exp_rd(input logic [4:0] d, input logic [15:0] r);
        if (d == DEV_LED && r == REG_LED_MODE) return {11'h000, m_led, LED_LOW_FIXED};
        if (d == DEV_WAKE && r == REG_WAKE_TIMER) return m_wake;
        if (d == DEV_ADVERT && r == REG_ADVERT) return {14'h0000, m_adv, 1'b0};
        return 16'h0000;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    // One strobe per access, idle cycle between, drops after the taking edge
    task automatic op(input logic [2:0] kind, input logic [15:0] d);
        @(posedge sys_clk_in);
        req_in <= {kind, d};
        @(posedge sys_clk_in);
        req_in <= '0;
        #1;
    endtask
    task automatic sel(input logic [4:0] d, input logic [15:0] r, input logic [1:0] fn);
        op(3'b100, {FUNC_ADDRESS, 9'h000, d});
        op(3'b010, r);
        op(3'b100, {fn, 9'h000, d});
    endtask
    task automatic rd_chk(input logic [15:0] exp);
        op(3'b001, 16'h0000);
        chk({15'h0000, rvalid_out}, 16'h0001, "rvalid");
        chk(rdata_out, exp, "rdata");
    endtask
    task automatic wr_reg(input logic [4:0] d, input logic [15:0] r, input logic [15:0] v);
        sel(d, r, FUNC_DATA);
        op(3'b010, v);
        if (d == DEV_LED && r == REG_LED_MODE) m_led = v[LED_MODE_BIT];
        if (d == DEV_WAKE && r == REG_WAKE_TIMER) m_wake = v;
        if (d == DEV_ADVERT && r == REG_ADVERT) m_adv = v[ADVERT_100_BIT];
    endtask
    task automatic outs();
        chk({15'h0000, single_led_out}, {15'h0000, m_led}, "single_led");
        chk({15'h0000, advert_100_out}, {15'h0000, m_adv}, "advert");
        chk(wake_refresh_time_out, m_wake, "wake");
    endtask
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        #200000;
        n_fail++;
        end_of_test();
    end
    initial
    begin
        repeat (6) @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
        #1;
        outs();
        sel(DEV_LED, REG_LED_MODE, FUNC_DATA);
        rd_chk(exp_rd(DEV_LED, REG_LED_MODE));
        wr_reg(DEV_LED, REG_LED_MODE, 16'h0010);
        outs();
        rd_chk(exp_rd(DEV_LED, REG_LED_MODE));
        wr_reg(DEV_WAKE, REG_WAKE_TIMER, 16'h0021);
        rd_chk(exp_rd(DEV_WAKE, REG_WAKE_TIMER));
        wr_reg(DEV_ADVERT, REG_ADVERT, 16'hfffd);
        rd_chk(exp_rd(DEV_ADVERT, REG_ADVERT));
        outs();
        // Address function read gives back the latched register address
        sel(DEV_ADVERT, 16'h1234, FUNC_ADDRESS);
        rd_chk(16'h1234);
        $display("directed tests done");
        repeat (24)
        begin
            seed = lfsr(seed);
            case (seed[1:0])
                2'h0:
                begin
                    dv = DEV_LED;
                    ra = REG_LED_MODE;
                end
                2'h1:
                begin
                    dv = DEV_WAKE;
                    ra = REG_WAKE_TIMER;
                end
                2'h2:
                begin
                    dv = DEV_ADVERT;
                    ra = REG_ADVERT;
                end
                default:
                begin
                    dv = seed[8:4];
                    ra = seed[31:16];
                end
            endcase
            // Only two timer values, 0021h and 0025h, are written
            wr_reg(dv, ra, (dv == DEV_WAKE) ? (seed[9] ? 16'h0021 : 16'h0025) : seed[17:2]);
            outs();
            rd_chk(exp_rd(dv, ra));
        end
        $display("random tests done");
        @(posedge sys_clk_in);
        sys_rst_in <= 1'b1;
        repeat (2) @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
        m_led = LED_MODE_RST;
        m_adv = ADVERT_100_RST;
        m_wake = WAKE_TIMER_RST;
        #1;
        outs();
        rd_chk(16'h0000);
        sel(DEV_ADVERT, REG_ADVERT, FUNC_DATA);
        rd_chk(exp_rd(DEV_ADVERT, REG_ADVERT));
        $display("reset test done");
        end_of_test();
    end
endmodule
